// ===== hw/spmp_pkg.sv
// Package with register map, field layout, timing counts and state types of the serial port.
package spmp_pkg;

    // ==========================================================================
    // Timing
    localparam int CLK_HZ      = 100_000_000;
    localparam int MAX_BIT_HZ  = 8_000_000;
    localparam int MIN_HALF    = (CLK_HZ + 2 * MAX_BIT_HZ - 1) / (2 * MAX_BIT_HZ);
    localparam int HALF_W      = 8;

    // ==========================================================================
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_FLAGS = 8'h17;
    localparam logic [7:0] IDX_MASK  = 8'h1e;
    localparam logic [7:0] IDX_CTRL  = 8'h36;
    localparam logic [7:0] IDX_STAT  = 8'h37;
    localparam logic [7:0] IDX_RXB   = 8'h38;
    localparam logic [7:0] IDX_TXB   = 8'h39;

    // ==========================================================================
    // Field positions
    localparam int CTRL_CES  = 7;
    localparam int CTRL_PEN  = 6;
    localparam int CTRL_SRO  = 5;
    localparam int CTRL_SSE  = 4;
    localparam int CTRL_OUT_IDLE_STATE_CTRL = 3;
    localparam int STAT_ORD  = 7;
    localparam int STAT_TDH  = 6;
    localparam int STAT_TDL  = 5;
    localparam int STAT_SSU  = 3;
    localparam int STAT_RBF  = 0;
    localparam int FLAG_SIF  = 3;
    localparam int MASK_SIE  = 3;

    // Baud codes from this value up select the external clock, that is slave mode.
    localparam logic [2:0] BAUD_EXT_MIN = 3'h5;

    // ==========================================================================
    // Types and reset values
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_MASTER = 2'b01,
        ST_SLAVE  = 2'b11
    } spmp_st_type;

    typedef struct packed {
        spmp_st_type        st;
        logic               clock_edge_select;
        logic               pen;
        logic               shift_start;
        logic               out_idle_state_ctrl;
        logic [2:0]         baud;
        logic               ord;
        logic [1:0]         td;
        logic               ssu;
        logic               rx_buffer_full;
        logic               sif;
        logic               sie;
        logic [7:0]         rxb;
        logic [7:0]         txb;
        logic [7:0]         sh;
        logic               inb;
        logic [3:0]         bits;
        logic [HALF_W-1:0]  half;
        logic               sck;
        logic               sdo;
        logic               pend;
        logic [1:0]         dly;
        logic [2:0]         sck_s;
        logic [2:0]         ss_s;
        logic [2:0]         sdi_s;
        logic               sck_f;
        logic               sck_p;
        logic               ss_f;
        logic               sdi_f;
        logic [31:0]        rdata;
        logic               err;
    } spmp_state_type;

    localparam spmp_state_type STATE_RST = '{
        st      : ST_IDLE,
        ss_s    : 3'h7,
        ss_f    : 1'b1,
        default : '0
    };

endpackage

// ===== hw/spmp_top.sv
// Byte-wide full-duplex serial port, master or slave, with an APB register slave.
//
// Operation
// - Master drives the serial clock; slave follows the external clock.
// - Each transfer shifts one byte out and one byte in together.
// - Most significant bit first by default; bit order select bit chooses order.
// - Receive buffer full flag sets once eight bits have shifted.
// - Completed byte goes to read buffer; full and interrupt flags set.
// - Reading the read buffer clears the receive buffer full flag.
// - Write buffer ignores writes while a shift is in progress.
// - Shift start loads and starts; reads one while the transfer runs.
// - Baud select picks shift clock rate or the external clock.
// - Clock edge select picks which clock edge shifts and latches.
// - In slave mode edge select and baud select have no effect.
// - Clock edge select clears when a byte completes.
// - Idle state control sets the data output level after a byte.
// - Two delay select bits delay the data output change.
// - Deselected slave ignores data and stops driving its output.
// - Serial input is ignored in slave mode whenever the port is not selected; master samples it regardless.
// - Both ends use the same clock rate and edge.
// - Slave select only qualifies slave mode; master ignores it.
// - Serial bit rate never exceeds 8 MHz.
// - Received bits replace transmitted bits in the shift register.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module spmp_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sck_i,
    output logic                   sck_o,
    output logic                   sck_oe,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe,
    input  wire logic              ss_n_i,
    output logic                   irq
);

    // ==========================================================================
    // Helpers
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
                 (i == spmp_pkg::IDX_FLAGS || i == spmp_pkg::IDX_MASK ||
                  i == spmp_pkg::IDX_CTRL  || i == spmp_pkg::IDX_STAT ||
                  i == spmp_pkg::IDX_RXB   || i == spmp_pkg::IDX_TXB);
    endfunction

    function automatic logic out_bit(input logic [7:0] s, input logic ord);
        out_bit = ord ? s[0] : s[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic ord,
                                            input logic b);
        shift_in = ord ? {b, s[7:1]} : {s[6:0], b};
    endfunction

    function automatic logic is_master(input logic [2:0] baud);
        is_master = baud < spmp_pkg::BAUD_EXT_MIN;
    endfunction

    // ==========================================================================
    // State
    spmp_pkg::spmp_state_type r;
    spmp_pkg::spmp_state_type n;
    logic                     done_c;
    logic                     start_c;
    logic                     wr_c;
    logic                     rd_c;
    logic [7:0]               idx;
    logic [7:0]               rv;
    logic [7:0]               sh_c;
    logic                     sel_c;
    logic [spmp_pkg::HALF_W-1:0] half_lim;

    assign idx = paddr[9:2];

    always_comb begin
        n        = r;
        done_c   = 1'b0;
        start_c  = 1'b0;
        sh_c     = r.sh;
        rv       = 8'h00;
        wr_c     = psel && penable && pwrite && !r.err;
        rd_c     = psel && penable && !pwrite && !r.err;
        half_lim = 8'((spmp_pkg::MIN_HALF << r.baud) - 1);
        sel_c    = !r.ssu || !r.ss_f;

        // Pin synchronisers; a change counts when the second and third stages agree.
        n.sck_s = {r.sck_s[1:0], sck_i};
        n.ss_s  = {r.ss_s[1:0], ss_n_i};
        n.sdi_s = {r.sdi_s[1:0], sdi_i};
        if (r.sck_s[1] == r.sck_s[2]) begin
            n.sck_f = r.sck_s[2];
        end
        if (r.ss_s[1] == r.ss_s[2]) begin
            n.ss_f = r.ss_s[2];
        end
        if (r.sdi_s[1] == r.sdi_s[2]) begin
            n.sdi_f = r.sdi_s[2];
        end
        n.sck_p = r.sck_f;

        // Read data is captured in the setup cycle and presented in the access phase.
        unique case (idx)
            spmp_pkg::IDX_CTRL: rv = {r.clock_edge_select, r.pen, ~r.ss_f, r.shift_start, r.out_idle_state_ctrl, r.baud};
            spmp_pkg::IDX_STAT: rv = {r.ord, r.td, 1'b0, r.ssu, 2'h0, r.rx_buffer_full};
            spmp_pkg::IDX_FLAGS: rv = {4'h0, r.sif, 3'h0};
            spmp_pkg::IDX_MASK: rv = {4'h0, r.sie, 3'h0};
            spmp_pkg::IDX_RXB: rv = r.rxb;
            spmp_pkg::IDX_TXB: rv = r.txb;
            default: rv = 8'h00;
        endcase
        if (psel && !penable) begin
            n.rdata = {24'h000000, rv};
            n.err   = !mapped(paddr);
        end

        if (r.pend) begin
            if (r.dly == 2'h0) begin
                n.sdo  = out_bit(r.sh, r.ord);
                n.pend = 1'b0;
            end else begin
                n.dly = r.dly - 2'h1;
            end
        end

        // Register writes; hardware sets below take priority over these clears.
        if (wr_c) begin
            unique case (idx)
                spmp_pkg::IDX_CTRL: begin
                    n.clock_edge_select  = pwdata[spmp_pkg::CTRL_CES];
                    n.pen  = pwdata[spmp_pkg::CTRL_PEN];
                    n.out_idle_state_ctrl = pwdata[spmp_pkg::CTRL_OUT_IDLE_STATE_CTRL];
                    n.baud = pwdata[2:0];
                    start_c = pwdata[spmp_pkg::CTRL_SSE] && pwdata[spmp_pkg::CTRL_PEN]
                              && !r.shift_start;
                end
                spmp_pkg::IDX_STAT: begin
                    n.ord = pwdata[spmp_pkg::STAT_ORD];
                    n.td  = {pwdata[spmp_pkg::STAT_TDH], pwdata[spmp_pkg::STAT_TDL]};
                    n.ssu = pwdata[spmp_pkg::STAT_SSU];
                    n.rx_buffer_full = pwdata[spmp_pkg::STAT_RBF];
                end
                spmp_pkg::IDX_FLAGS: n.sif = pwdata[spmp_pkg::FLAG_SIF];
                spmp_pkg::IDX_MASK: n.sie = pwdata[spmp_pkg::MASK_SIE];
                spmp_pkg::IDX_TXB: begin
                    if (!r.shift_start) begin
                        n.txb = pwdata[7:0];
                    end
                end
                default: n.err = r.err;
            endcase
        end
        if (rd_c && idx == spmp_pkg::IDX_RXB) begin
            n.rx_buffer_full = 1'b0;
        end

        // Transfer start loads the shift register and schedules the first bit.
        if (start_c) begin
            n.shift_start  = 1'b1;
            n.sh   = r.txb;
            n.bits = 4'h0;
            n.half = '0;
            n.pend = 1'b1;
            n.dly  = r.td;
            // Baud code selects internal or external clock
            n.st   = is_master(pwdata[2:0]) ? spmp_pkg::ST_MASTER : spmp_pkg::ST_SLAVE;
            n.sck  = pwdata[spmp_pkg::CTRL_CES];
        end

        unique case (r.st)
            spmp_pkg::ST_IDLE: begin
                if (!start_c) begin
                    n.sck = r.clock_edge_select;
                end
            end
            spmp_pkg::ST_MASTER: begin
                // Master generates the clock; half period at least MIN_HALF
                if (r.half >= half_lim) begin
                    n.half = '0;
                    n.sck  = ~r.sck;
                    // Leaving the idle level latches, returning shifts
                    if (r.sck == r.clock_edge_select) begin
                        n.inb = r.sdi_f;
                    end else begin
                        sh_c   = shift_in(r.sh, r.ord, r.inb);
                        n.sh   = sh_c;
                        n.bits = r.bits + 4'h1;
                        n.pend = 1'b1;
                        n.dly  = r.td;
                        done_c = (r.bits == 4'h7);
                    end
                end else begin
                    n.half = r.half + 1'b1;
                end
            end
            spmp_pkg::ST_SLAVE: begin
                // Fixed edges in slave mode; act only when selected
                if (sel_c) begin
                    if (r.sck_f && !r.sck_p) begin
                        n.inb = r.sdi_f;
                    end else if (!r.sck_f && r.sck_p) begin
                        sh_c   = shift_in(r.sh, r.ord, r.inb);
                        n.sh   = sh_c;
                        n.bits = r.bits + 4'h1;
                        n.pend = 1'b1;
                        n.dly  = r.td;
                        done_c = (r.bits == 4'h7);
                    end
                end
            end
            default: n.st = spmp_pkg::ST_IDLE;
        endcase

        // Byte complete; the sets win over software clears.
        if (done_c) begin
            n.rxb  = sh_c;
            n.rx_buffer_full  = 1'b1;
            n.sif  = 1'b1;
            n.shift_start  = 1'b0;
            n.st   = spmp_pkg::ST_IDLE;
            n.clock_edge_select  = 1'b0;
            n.sck  = 1'b0;
            n.sdo  = r.out_idle_state_ctrl;
            n.pend = 1'b0;
        end

        if (!r.pen && !start_c) begin
            n.st  = spmp_pkg::ST_IDLE;
            n.shift_start = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= spmp_pkg::STATE_RST;
        end else begin
            r <= n;
        end
    end

    // ==========================================================================
    // Outputs
    assign prdata  = r.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && r.err;
    assign sck_o   = r.sck;
    assign sdo_o   = r.sdo;
    // Slave select qualifies slave mode only
    assign sck_oe  = r.pen && is_master(r.baud);
    assign sdo_oe  = r.pen && (is_master(r.baud) || !r.ssu || !r.ss_f);
    assign irq     = r.sif && r.sie;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_irq_flag_gate: assert property (
        done_c && r.sie |=> irq)
        else $error("interrupt did not rise after a completed byte");

    a_busy_on_start: assert property (
        start_c |=> r.shift_start throughout (!done_c && r.pen)[*3])
        else $error("shift start not held while transfer runs");

    a_done_sets_flags: assert property (
        done_c |=> r.rx_buffer_full && r.sif && r.rxb == $past(sh_c))
        else $error("completed byte not moved with flags set");

    a_txb_locked: assert property (
        wr_c && idx == spmp_pkg::IDX_TXB && r.shift_start |=> $stable(r.txb))
        else $error("write buffer changed during a shift");

    a_rbf_read_clear: assert property (
        rd_c && idx == spmp_pkg::IDX_RXB && !done_c |=> !r.rx_buffer_full)
        else $error("read buffer read did not clear full flag");

    a_ces_done_clear: assert property (
        done_c |=> !r.clock_edge_select)
        else $error("edge select not cleared after byte");

    a_slave_release: assert property (
        !is_master(r.baud) && r.ssu && r.ss_f |-> !sdo_oe)
        else $error("deselected slave drives data output");

    a_full_after_eight: assert property (
        done_c |-> r.bits == 4'h7 && r.st != spmp_pkg::ST_IDLE)
        else $error("full flag set before eight bits");

    a_half_min_len: assert property (
        r.st == spmp_pkg::ST_MASTER && $changed(sck_o) |=> $stable(sck_o)[*6])
        else $error("serial clock half period too short");

    a_idle_level: assert property (
        done_c |=> sdo_o == $past(r.out_idle_state_ctrl))
        else $error("data output not at idle level after byte");

    a_sse_done_clear: assert property (
        done_c |=> !r.shift_start)
        else $error("shift start still set after byte");

    a_start_loads: assert property (
        start_c |=> r.shift_start && r.sh == $past(r.txb))
        else $error("shift start did not load the write buffer");

    a_busy_read_one: assert property (
        psel && !penable && idx == spmp_pkg::IDX_CTRL && r.shift_start |=> prdata[spmp_pkg::CTRL_SSE])
        else $error("shift start did not read as one while busy");

    a_msb_first_out: assert property (
        r.pend && r.dly == 2'h0 && !done_c && !r.ord |=> sdo_o == $past(r.sh[7]))
        else $error("data output bit not taken from the top");

    a_lsb_first_out: assert property (
        r.pend && r.dly == 2'h0 && !done_c && r.ord |=> sdo_o == $past(r.sh[0]))
        else $error("data output bit not taken from the bottom");

    a_delay_hold: assert property (
        r.pend && r.dly != 2'h0 && !done_c |=> $stable(sdo_o))
        else $error("data output changed before its delay ran out");

    a_slave_no_clk: assert property (
        !is_master(r.baud) |-> !sck_oe)
        else $error("serial clock driven with external clock selected");

    a_desel_freeze: assert property (
        r.st == spmp_pkg::ST_SLAVE && !sel_c |=> $stable(r.sh) && $stable(r.bits))
        else $error("deselected slave shifted data");

    a_slave_fixed_edge: assert property (
        r.st == spmp_pkg::ST_SLAVE && sel_c && r.sck_f && !r.sck_p |=> r.inb == $past(r.sdi_f))
        else $error("slave did not sample on the rising clock");

    a_bits_bound: assert property (
        r.st != spmp_pkg::ST_IDLE |-> r.bits <= 4'h7)
        else $error("more than eight bits in one transfer");

    a_idle_clock: assert property (
        r.st == spmp_pkg::ST_IDLE && !start_c |=> sck_o == $past(r.clock_edge_select))
        else $error("idle serial clock not at edge select level");

    a_irq_masked: assert property (
        !r.sie |-> !irq)
        else $error("interrupt raised while disabled");

    a_rbf_sticky: assert property (
        r.rx_buffer_full && !(rd_c && idx == spmp_pkg::IDX_RXB) && !(wr_c && idx == spmp_pkg::IDX_STAT)
            |=> r.rx_buffer_full)
        else $error("full flag dropped without a read");

endmodule // spmp_top

// ===== tb/spmp_far_end.sv
// Behavioural far-end serial device: slave on the wire, or clock source for slave tests.
`timescale 1ns/100ps
module spmp_far_end (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       ld,
    input  wire logic       gen,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic            sck_drv,
    output logic            ss_n,
    output logic [7:0]      rx
);
    logic [7:0] sh;
    int         cnt;

    // ==========================================================================
    // Start values
    initial begin
        sck_drv = 1'b0;
        ss_n = 1'b1;
        miso = 1'b0;
        rx = 8'h00;
        cnt = 8;
    end

    // ==========================================================================
    // Shifting
    always @(posedge ld) begin
        sh = tx;
        miso = tx[7];
        cnt = 0;
        rx = 8'h00;
    end

    always @(posedge (sck ^ cpol)) begin
        if (cnt < 8) begin
            rx <= {rx[6:0], mosi};
            cnt <= cnt + 1;
        end
    end

    // shift on trailing edge; bits past the frame keep changing.
    always @(negedge (sck ^ cpol)) begin
        sh = {sh[6:0], ~sh[7]};
        miso = sh[7];
    end

    // ==========================================================================
    // Clock source
    // select spans frame.
    always @(posedge gen) begin
        ss_n = 1'b0;
        #200;
        repeat (8) begin
            sck_drv = 1'b1;
            #62.5;
            sck_drv = 1'b0;
            #62.5;
        end
        #200;
        ss_n = 1'b1;
    end
endmodule // spmp_far_end

// ===== tb/tb.sv
// Self-checking bench for the serial port: register access and serial transfers.
`timescale 1ns/100ps
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_o;
    logic        sck_oe;
    logic        sdo_o;
    logic        sdo_oe;
    logic        irq;
    logic        miso;
    logic        sck_drv;
    logic        ss_n;
    logic [7:0]  far_rx;
    logic [7:0]  far_tx;
    logic        cpol;
    logic        ld;
    logic        gen;
    logic [31:0] rd;
    logic        serr;
    int          err_total;
    int          cmp_count;
    wire         sck_w = sck_oe ? sck_o : sck_drv;
    wire         mosi = sdo_oe ? sdo_o : 1'bz;

    spmp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(miso),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n), .irq(irq));

    spmp_far_end u_far (.sck(sck_w), .mosi(mosi), .cpol(cpol), .ld(ld), .gen(gen),
        .tx(far_tx), .miso(miso), .sck_drv(sck_drv), .ss_n(ss_n), .rx(far_rx));

    // ==========================================================================
    // Clock and helpers
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7-i];
        return r;
    endfunction

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) err_total++;
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 8'h00);
        chk(nm, exp, rd);
    endtask

    task automatic load_far(input logic [7:0] v);
        @(posedge pclk);
        far_tx <= v;
        ld <= 1'b1;
        @(posedge pclk);
        ld <= 1'b0;
    endtask

    task automatic wait_done;
        int k;
        k = 0;
        do begin
            apb(1'b0, spmp_pkg::IDX_CTRL, 8'h00);
            k++;
        end while (rd[spmp_pkg::CTRL_SSE] === 1'b1 && k < 400);
        if (k == 400) err_total++;
    endtask

    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================================
    // Tests
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, cpol, ld, gen, far_tx} = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(spmp_pkg::IDX_CTRL, 32'h0, "control reset");
        rdchk(spmp_pkg::IDX_STAT, 32'h0, "status reset");
        rdchk(spmp_pkg::IDX_FLAGS, 32'h0, "flags reset");
        apb(1'b0, 8'h3f, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, serr});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, spmp_pkg::IDX_MASK, 8'h08);
        apb(1'b1, spmp_pkg::IDX_TXB, 8'ha5);
        load_far(8'h3c);
        apb(1'b1, spmp_pkg::IDX_CTRL, 8'h50);
        apb(1'b0, spmp_pkg::IDX_CTRL, 8'h00);
        chk("busy bit", 32'h1, {31'h0, rd[spmp_pkg::CTRL_SSE]});
        chk("clock drive", 32'h1, {31'h0, sck_oe});
        apb(1'b1, spmp_pkg::IDX_TXB, 8'hff);
        wait_done;
        chk("far end byte", 32'ha5, {24'h0, far_rx});
        rdchk(spmp_pkg::IDX_STAT, 32'h01, "full flag");
        rdchk(spmp_pkg::IDX_FLAGS, 32'h08, "irq flag");
        chk("irq line", 32'h1, {31'h0, irq});
        rdchk(spmp_pkg::IDX_TXB, 32'ha5, "write buffer");
        rdchk(spmp_pkg::IDX_RXB, 32'h3c, "read buffer");
        rdchk(spmp_pkg::IDX_STAT, 32'h00, "full cleared");
        apb(1'b1, spmp_pkg::IDX_FLAGS, 8'h00);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, spmp_pkg::IDX_STAT, 8'he0);
        apb(1'b1, spmp_pkg::IDX_CTRL, 8'hc0);
        @(posedge pclk);
        cpol <= 1'b1;
        load_far(8'h12);
        apb(1'b1, spmp_pkg::IDX_TXB, 8'h5a);
        apb(1'b1, spmp_pkg::IDX_CTRL, 8'hd9);
        wait_done;
        chk("lsb first out", {24'h0, rev8(8'h5a)}, {24'h0, far_rx});
        rdchk(spmp_pkg::IDX_RXB, {24'h0, rev8(8'h12)}, "lsb first in");
        rdchk(spmp_pkg::IDX_CTRL, 32'h49, "edge select cleared");
        chk("idle data level", 32'h1, {31'h0, sdo_o});
        chk("idle clock level", 32'h0, {31'h0, sck_o});
        @(posedge pclk);
        cpol <= 1'b0;
        apb(1'b1, spmp_pkg::IDX_STAT, 8'h08);
        apb(1'b1, spmp_pkg::IDX_TXB, 8'h3b);
        apb(1'b1, spmp_pkg::IDX_CTRL, 8'hd5);
        chk("slave clock input", 32'h0, {31'h0, sck_oe});
        chk("deselected output", 32'h0, {31'h0, sdo_oe});
        load_far(8'h96);
        @(posedge pclk);
        gen <= 1'b1;
        wait_done;
        gen <= 1'b0;
        chk("slave out byte", 32'h3b, {24'h0, far_rx});
        rdchk(spmp_pkg::IDX_RXB, 32'h96, "slave in byte");
        wrap_up;
    end

    initial begin
        #300000;
        err_total++;
        wrap_up;
    end
endmodule // tb
